// >>> pdc_pkg.sv
package pdc_pkg;

  // ****************************************************
  // Register offsets (byte addresses on the management port)
  // ****************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OFS_OUT2_DIVIDER_LOW_BYTE = 8'h24;
  localparam logic [7:0] OFS_FEEDBACK_HS_AND_LS_TOP = 8'h28;
  localparam logic [7:0] OFS_FEEDBACK_LS_MID_BYTE = 8'h29;
  localparam logic [7:0] OFS_FEEDBACK_LS_LOW_BYTE = 8'h2A;
  localparam logic [7:0] OFS_INPUT1_PREDIV_TOP = 8'h2B;
  localparam logic [7:0] OFS_INPUT1_PREDIV_MID = 8'h2C;
  localparam logic [7:0] OFS_INPUT1_PREDIV_LOW = 8'h2D;
  localparam logic [7:0] OFS_INPUT2_PREDIV_TOP = 8'h2E;
  localparam logic [7:0] OFS_INPUT2_PREDIV_MID = 8'h2F;
  localparam logic [7:0] OFS_INPUT2_PREDIV_LOW = 8'h30;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [7:0] RST_OUT2_DIVIDER_LOW_BYTE = 8'h31;
  localparam logic [7:0] RST_FEEDBACK_HS_AND_LS_TOP = 8'hC0;
  localparam logic [7:0] RST_FEEDBACK_LS_MID_BYTE = 8'h00;
  localparam logic [7:0] RST_FEEDBACK_LS_LOW_BYTE = 8'hF9;
  localparam logic [7:0] RST_INPUT1_PREDIV_TOP = 8'h00;
  localparam logic [7:0] RST_INPUT1_PREDIV_MID = 8'h00;
  localparam logic [7:0] RST_INPUT1_PREDIV_LOW = 8'h09;
  localparam logic [7:0] RST_INPUT2_PREDIV_TOP = 8'h00;
  localparam logic [7:0] RST_INPUT2_PREDIV_MID = 8'h00;
  localparam logic [7:0] RST_INPUT2_PREDIV_LOW = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ****************************************************
  // Field positions and widths
  // ****************************************************
  localparam int unsigned HS_CODE_MSB = 7;
  localparam int unsigned HS_CODE_LSB = 5;
  localparam int unsigned HS_CODE_W = 3;
  localparam int unsigned FB_TOP_MSB = 3;
  localparam int unsigned PREDIV_TOP_MSB = 2;
  localparam int unsigned FB_LS_W = 20;
  localparam int unsigned PREDIV_W = 19;
  localparam int unsigned OUT2_LS_W = 20;
  localparam int unsigned OUT2_UPPER_W = 12;
  localparam int unsigned HS_CNT_W = 4;
  // Code 000 divides by 4, so the terminal count is code plus 3
  localparam logic [3:0] HS_TERM_BASE = 4'h3;

endpackage : pdc_pkg

// >>> pdc_ediv.sv
`timescale 1ns/1ps
module pdc_ediv #(
  parameter int unsigned W = 20
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic step_i,
  input wire logic [W-1:0] term_i,
  output logic tick_o
);

  // ****************************************************
  // Event divider: one tick per term_i+1 steps
  // ****************************************************
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // Compare with >= so a ratio lowered mid-count wraps at once
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (step_i) begin
      if (cnt_r >= term_i) begin
        cnt_nxt = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule : pdc_ediv

// >>> pdc_top.sv
// Behaviour
// - Clock out b divides by out2 field plus one
// - Feedback high-speed code gives ratio 4 to 11
// - Feedback low-speed output feeds phase detector
// - Feedback low-speed ratio is field plus one
// - Input a pre-divider ratio is field plus one
// - Input b pre-divider, zero means divide-by-one
// - Divider registers take documented reset values
`timescale 1ns/1ps
module pdc_top
  import pdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic [OUT2_UPPER_W-1:0] out2_div_upper_i,
  input wire logic hs_common_clk_i,
  input wire logic vco_feedback_clk_i,
  input wire logic clock_in_a_i,
  input wire logic clock_in_b_i,
  output logic clock_out_b_o,
  output logic pd_feedback_o,
  output logic pd_ref_a_o,
  output logic pd_ref_b_o
);

  // ****************************************************
  // Register file
  // ****************************************************
  logic [7:0] out2_divider_low_byte_r;
  logic [7:0] out2_divider_low_byte_nxt;
  logic [7:0] feedback_hs_and_ls_top_r;
  logic [7:0] feedback_hs_and_ls_top_nxt;
  logic [7:0] feedback_ls_mid_byte_r;
  logic [7:0] feedback_ls_mid_byte_nxt;
  logic [7:0] feedback_ls_low_byte_r;
  logic [7:0] feedback_ls_low_byte_nxt;
  logic [7:0] input1_prediv_top_r;
  logic [7:0] input1_prediv_top_nxt;
  logic [7:0] input1_prediv_mid_r;
  logic [7:0] input1_prediv_mid_nxt;
  logic [7:0] input1_prediv_low_r;
  logic [7:0] input1_prediv_low_nxt;
  logic [7:0] input2_prediv_top_r;
  logic [7:0] input2_prediv_top_nxt;
  logic [7:0] input2_prediv_mid_r;
  logic [7:0] input2_prediv_mid_nxt;
  logic [7:0] input2_prediv_low_r;
  logic [7:0] input2_prediv_low_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Reserved bits are never stored, so they always read back as zero
  always_comb begin
    out2_divider_low_byte_nxt = out2_divider_low_byte_r;
    feedback_hs_and_ls_top_nxt = feedback_hs_and_ls_top_r;
    feedback_ls_mid_byte_nxt = feedback_ls_mid_byte_r;
    feedback_ls_low_byte_nxt = feedback_ls_low_byte_r;
    input1_prediv_top_nxt = input1_prediv_top_r;
    input1_prediv_mid_nxt = input1_prediv_mid_r;
    input1_prediv_low_nxt = input1_prediv_low_r;
    input2_prediv_top_nxt = input2_prediv_top_r;
    input2_prediv_mid_nxt = input2_prediv_mid_r;
    input2_prediv_low_nxt = input2_prediv_low_r;
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_OUT2_DIVIDER_LOW_BYTE: begin
          out2_divider_low_byte_nxt = reg_wdata_i;
        end
        OFS_FEEDBACK_HS_AND_LS_TOP: begin
          feedback_hs_and_ls_top_nxt = {reg_wdata_i[HS_CODE_MSB:HS_CODE_LSB], 1'b0, reg_wdata_i[FB_TOP_MSB:0]};
        end
        OFS_FEEDBACK_LS_MID_BYTE: begin
          feedback_ls_mid_byte_nxt = reg_wdata_i;
        end
        OFS_FEEDBACK_LS_LOW_BYTE: begin
          feedback_ls_low_byte_nxt = reg_wdata_i;
        end
        OFS_INPUT1_PREDIV_TOP: begin
          input1_prediv_top_nxt = {5'h00, reg_wdata_i[PREDIV_TOP_MSB:0]};
        end
        OFS_INPUT1_PREDIV_MID: begin
          input1_prediv_mid_nxt = reg_wdata_i;
        end
        OFS_INPUT1_PREDIV_LOW: begin
          input1_prediv_low_nxt = reg_wdata_i;
        end
        OFS_INPUT2_PREDIV_TOP: begin
          input2_prediv_top_nxt = {5'h00, reg_wdata_i[PREDIV_TOP_MSB:0]};
        end
        OFS_INPUT2_PREDIV_MID: begin
          input2_prediv_mid_nxt = reg_wdata_i;
        end
        OFS_INPUT2_PREDIV_LOW: begin
          input2_prediv_low_nxt = reg_wdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data is registered so the port sees a flop, at one cycle of latency
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_OUT2_DIVIDER_LOW_BYTE: begin
          rdata_nxt = out2_divider_low_byte_r;
        end
        OFS_FEEDBACK_HS_AND_LS_TOP: begin
          rdata_nxt = feedback_hs_and_ls_top_r;
        end
        OFS_FEEDBACK_LS_MID_BYTE: begin
          rdata_nxt = feedback_ls_mid_byte_r;
        end
        OFS_FEEDBACK_LS_LOW_BYTE: begin
          rdata_nxt = feedback_ls_low_byte_r;
        end
        OFS_INPUT1_PREDIV_TOP: begin
          rdata_nxt = input1_prediv_top_r;
        end
        OFS_INPUT1_PREDIV_MID: begin
          rdata_nxt = input1_prediv_mid_r;
        end
        OFS_INPUT1_PREDIV_LOW: begin
          rdata_nxt = input1_prediv_low_r;
        end
        OFS_INPUT2_PREDIV_TOP: begin
          rdata_nxt = input2_prediv_top_r;
        end
        OFS_INPUT2_PREDIV_MID: begin
          rdata_nxt = input2_prediv_mid_r;
        end
        OFS_INPUT2_PREDIV_LOW: begin
          rdata_nxt = input2_prediv_low_r;
        end
        default: begin
          rdata_nxt = RD_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out2_divider_low_byte_r <= RST_OUT2_DIVIDER_LOW_BYTE;
      feedback_hs_and_ls_top_r <= RST_FEEDBACK_HS_AND_LS_TOP;
      feedback_ls_mid_byte_r <= RST_FEEDBACK_LS_MID_BYTE;
      feedback_ls_low_byte_r <= RST_FEEDBACK_LS_LOW_BYTE;
      input1_prediv_top_r <= RST_INPUT1_PREDIV_TOP;
      input1_prediv_mid_r <= RST_INPUT1_PREDIV_MID;
      input1_prediv_low_r <= RST_INPUT1_PREDIV_LOW;
      input2_prediv_top_r <= RST_INPUT2_PREDIV_TOP;
      input2_prediv_mid_r <= RST_INPUT2_PREDIV_MID;
      input2_prediv_low_r <= RST_INPUT2_PREDIV_LOW;
    end else begin
      out2_divider_low_byte_r <= out2_divider_low_byte_nxt;
      feedback_hs_and_ls_top_r <= feedback_hs_and_ls_top_nxt;
      feedback_ls_mid_byte_r <= feedback_ls_mid_byte_nxt;
      feedback_ls_low_byte_r <= feedback_ls_low_byte_nxt;
      input1_prediv_top_r <= input1_prediv_top_nxt;
      input1_prediv_mid_r <= input1_prediv_mid_nxt;
      input1_prediv_low_r <= input1_prediv_low_nxt;
      input2_prediv_top_r <= input2_prediv_top_nxt;
      input2_prediv_mid_r <= input2_prediv_mid_nxt;
      input2_prediv_low_r <= input2_prediv_low_nxt;
    end
  end

  // Read data has its own flop group; it holds until the next read
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= RD_UNMAPPED;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ****************************************************
  // Pin synchronisers and rising-edge detection
  // ****************************************************
  // Order: 0 common high-speed, 1 feedback, 2 input a, 3 input b
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [3:0] pin_s3_r;
  logic [3:0] pin_rise;
  logic [3:0] pin_s1_nxt;
  logic [3:0] pin_s2_nxt;
  logic [3:0] pin_s3_nxt;

  // Only the second and third stages feed logic; the first may still be metastable
  always_comb begin
    pin_s1_nxt = {clock_in_b_i, clock_in_a_i, vco_feedback_clk_i, hs_common_clk_i};
    pin_s2_nxt = pin_s1_r;
    pin_s3_nxt = pin_s2_r;
  end

  // The divider clocks must be well below clk_i/2 or edges are lost
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      pin_s3_r <= 4'h0;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
      pin_s3_r <= pin_s3_nxt;
    end
  end

  // Stages reset low like idle pins, so no false edge follows reset
  assign pin_rise = pin_s2_r & ~pin_s3_r;

  // ****************************************************
  // Divider chains
  // ****************************************************
  logic [OUT2_LS_W-1:0] out2_term;
  logic [HS_CNT_W-1:0] fb_hs_term;
  logic [FB_LS_W-1:0] fb_ls_term;
  logic [PREDIV_W-1:0] in_a_term;
  logic [PREDIV_W-1:0] in_b_term;
  logic fb_hs_tick;
  logic [HS_CODE_W-1:0] fb_hs_code;
  logic [FB_TOP_MSB:0] fb_ls_top;
  logic [PREDIV_TOP_MSB:0] in_a_top;
  logic [PREDIV_TOP_MSB:0] in_b_top;

  // Field slices; reserved bits never reach a divider
  assign fb_hs_code = feedback_hs_and_ls_top_r[HS_CODE_MSB:HS_CODE_LSB];
  assign fb_ls_top = feedback_hs_and_ls_top_r[FB_TOP_MSB:0];
  assign in_a_top = input1_prediv_top_r[PREDIV_TOP_MSB:0];
  assign in_b_top = input2_prediv_top_r[PREDIV_TOP_MSB:0];

  // Upper out2 bytes live in registers outside this block
  assign out2_term = {out2_div_upper_i, out2_divider_low_byte_r};
  // Code 000 must divide by four, hence the base of three
  assign fb_hs_term = HS_TERM_BASE + {1'b0, fb_hs_code};
  assign fb_ls_term = {fb_ls_top, feedback_ls_mid_byte_r, feedback_ls_low_byte_r};
  assign in_a_term = {in_a_top, input1_prediv_mid_r, input1_prediv_low_r};
  assign in_b_term = {in_b_top, input2_prediv_mid_r, input2_prediv_low_r};

  // ****************************************************
  // Output b divider
  // ****************************************************

  // Ratio is term plus one, so zero passes every edge through
  pdc_ediv #(.W(OUT2_LS_W)) u_out2_ls (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .step_i(pin_rise[0]),
    .term_i(out2_term),
    .tick_o(clock_out_b_o)
  );

  // ****************************************************
  // Feedback path
  // ****************************************************

  pdc_ediv #(.W(HS_CNT_W)) u_fb_hs (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .step_i(pin_rise[1]),
    .term_i(fb_hs_term),
    .tick_o(fb_hs_tick)
  );

  // Clocked by the high-speed stage; ratio is field plus one
  pdc_ediv #(.W(FB_LS_W)) u_fb_ls (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .step_i(fb_hs_tick),
    .term_i(fb_ls_term),
    .tick_o(pd_feedback_o)
  );

  // ****************************************************
  // Input pre-dividers
  // ****************************************************

  pdc_ediv #(.W(PREDIV_W)) u_in_a (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .step_i(pin_rise[2]),
    .term_i(in_a_term),
    .tick_o(pd_ref_a_o)
  );

  pdc_ediv #(.W(PREDIV_W)) u_in_b (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .step_i(pin_rise[3]),
    .term_i(in_b_term),
    .tick_o(pd_ref_b_o)
  );

endmodule : pdc_top

// >>> pdc_top_properties.sv
`timescale 1ns/1ps
module pdc_top_chk
  import pdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic [OUT2_UPPER_W-1:0] out2_div_upper_i,
  input wire logic hs_common_clk_i,
  input wire logic vco_feedback_clk_i,
  input wire logic clock_in_a_i,
  input wire logic clock_in_b_i,
  input wire logic clock_out_b_o,
  input wire logic pd_feedback_o,
  input wire logic pd_ref_a_o,
  input wire logic pd_ref_b_o
);
  // ****************************************************
  // Properties
  // ****************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic mapped;
  assign mapped = reg_addr_i inside {8'h24, [8'h28:8'h30]};
  a_out2_quiet: assert property ((!hs_common_clk_i)[*5] |-> !clock_out_b_o) else $error("out2 pulse, idle pin");
  a_fb_spacing: assert property (pd_feedback_o |=> !pd_feedback_o[*7]) else $error("feedback pulses too close");
  a_fb_quiet: assert property ((!vco_feedback_clk_i)[*5] |-> !pd_feedback_o) else $error("feedback pulse, idle pin");
  a_fb_readback: assert property ((reg_wr_i && reg_addr_i == OFS_FEEDBACK_LS_MID_BYTE) ##1 !reg_wr_i
    ##1 (reg_rd_i && !reg_wr_i && reg_addr_i == OFS_FEEDBACK_LS_MID_BYTE) |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("feedback mid byte readback wrong");
  a_refa_quiet: assert property ((!clock_in_a_i)[*5] |-> !pd_ref_a_o) else $error("ref a pulse, idle pin");
  a_refb_quiet: assert property ((!clock_in_b_i)[*5] |-> !pd_ref_b_o) else $error("ref b pulse, idle pin");
  a_unmapped_zero: assert property (reg_rd_i && !mapped |=> reg_rdata_o == RD_UNMAPPED) else $error("unmapped read");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
  cover property (pd_feedback_o);
  cover property (clock_out_b_o);
  cover property (reg_rd_i && !mapped);
endmodule : pdc_top_chk

bind pdc_top pdc_top_chk pdc_top_chk_inst (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .out2_div_upper_i(out2_div_upper_i), .hs_common_clk_i(hs_common_clk_i), .vco_feedback_clk_i(vco_feedback_clk_i),
  .clock_in_a_i(clock_in_a_i), .clock_in_b_i(clock_in_b_i), .clock_out_b_o(clock_out_b_o),
  .pd_feedback_o(pd_feedback_o), .pd_ref_a_o(pd_ref_a_o), .pd_ref_b_o(pd_ref_b_o));

// >>> pdc_host.sv
`timescale 1ns/1ps
module pdc_host
  import pdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic [DATA_W-1:0] reg_rdata_i,
  output logic [ADDR_W-1:0] reg_addr_o,
  output logic [DATA_W-1:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  // ****************************************************
  // Host bus cycles, one request held across its taking edge
  // ****************************************************
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask : read_reg
  // Bytes are not shadowed, so every byte goes before the ratio is used
  task automatic write_div(input logic [7:0] top, input logic [7:0] tb, input logic [15:0] lo);
    write_reg(top, tb);
    write_reg(top + 8'h01, lo[15:8]);
    write_reg(top + 8'h02, lo[7:0]);
  endtask : write_div
endmodule : pdc_host

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import pdc_pkg::*;
  // ****************************************************
  // Bench
  // ****************************************************
  logic clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd, d;
  logic [11:0] out2_div_upper_i = 12'h000;
  logic [3:0] run = 4'h0, pins;
  wire [3:0] pls;
  logic [1:0] ph = 2'h0;
  int miscompares = 0, total_checks = 0, v;
  int mirror[int];
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) ph <= #1 ph + 2'h1;
  // Pins idle low between measurements, period four clocks
  assign pins = run & {4{ph[1]}};
  pdc_host pdc_host_inst (.clk_i(clk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
  pdc_top pdc_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .out2_div_upper_i(out2_div_upper_i),
    .hs_common_clk_i(pins[0]), .vco_feedback_clk_i(pins[1]), .clock_in_a_i(pins[2]), .clock_in_b_i(pins[3]),
    .clock_out_b_o(pls[0]), .pd_feedback_o(pls[1]), .pd_ref_a_o(pls[2]), .pd_ref_b_o(pls[3]));
  function automatic logic [7:0] msk(input logic [7:0] x);
    return (x == 8'h28) ? 8'hEF : (x == 8'h2B || x == 8'h2E) ? 8'h07 : 8'hFF;
  endfunction : msk
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : check
  // First pulses after a change may be short, so only the third gap counts
  task automatic spacing(input int s, input int exp, input string what);
    int n;
    run = 4'h0;
    run[s] = 1'b1;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clk_i);
        #1;
        n++;
      end while (pls[s] !== 1'b1 && n < 20000);
    end
    run = 4'h0;
    check(n, exp, what);
  endtask : spacing
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    void'($urandom(32588));
    mirror = '{8'h24: 8'h31, 8'h28: 8'hC0, 8'h29: 8'h00, 8'h2A: 8'hF9, 8'h2B: 8'h00, 8'h2C: 8'h00, 8'h2D: 8'h09,
      8'h2E: 8'h00, 8'h2F: 8'h00, 8'h30: 8'h00, 8'h31: 8'h00, 8'h25: 8'h00};
    repeat (10) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    foreach (mirror[k]) begin
      pdc_host_inst.read_reg(k[7:0], rd);
      check(rd, mirror[k], "reset value");
    end
    $display("test reset values done");
    foreach (mirror[k]) begin
      d = 8'($urandom);
      if (k == 8'h24 || k == 8'h2A) d[0] = 1'b1;
      pdc_host_inst.write_reg(k[7:0], d);
      mirror[k] = (k == 8'h31 || k == 8'h25) ? 0 : d & msk(k[7:0]);
      pdc_host_inst.read_reg(k[7:0], rd);
      check(rd, mirror[k], "readback");
    end
    $display("test register access done");
    for (int t = 0; t < 9; t += 1 + ($urandom % 3) * 2) begin
      pdc_host_inst.write_reg(8'h24, t[7:0]);
      spacing(0, 4 * (t + 1), "out2 ratio");
    end
    out2_div_upper_i = 12'h001;
    pdc_host_inst.write_reg(8'h24, 8'h01);
    spacing(0, 4 * 258, "out2 upper ratio");
    out2_div_upper_i = 12'h000;
    $display("test out2 done");
    for (int c = 0; c < 8; c++) begin
      pdc_host_inst.write_div(8'h28, {c[2:0], 5'h00}, 16'h0001);
      spacing(1, 8 * (c + 4), "feedback hs ratio");
    end
    v = 3 + ($urandom % 7) * 2;
    pdc_host_inst.write_div(8'h28, 8'h00, v[15:0]);
    spacing(1, 16 * (v + 1), "feedback ls ratio");
    $display("test feedback done");
    for (int s = 2; s < 4; s++) begin
      v = (s == 3) ? 0 : $urandom % 10;
      pdc_host_inst.write_div(8'h2B + 8'((s - 2) * 3), 8'h00, v[15:0]);
      spacing(s, 4 * (v + 1), "input pre-divider ratio");
      v = 1 + $urandom % 9;
      pdc_host_inst.write_div(8'h2B + 8'((s - 2) * 3), 8'h00, v[15:0]);
      spacing(s, 4 * (v + 1), "input pre-divider ratio");
    end
    $display("test pre-dividers done");
    print_verdict();
  end
endmodule : testbench
